// File: busmaster_assertions.sv
// checker on the wires between board and backplane
// assumes clk samples every wire and srst is synchronous
`timescale 1ns/1ps
module busmaster_assertions
(
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // link wires
   input wire logic bclk,
   input wire logic busy_n_oe,
   input wire logic cbrq_n_oe,
   input wire logic far_busy_n_oe,
   input wire logic bus_request_out_n,
   input wire logic priority_in_n,
   // test input
   input wire logic forced_grant_in
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);
   // ========
   // properties
   property p_reset_idle;
      $fell(srst) |-> bus_request_out_n && !busy_n_oe && !cbrq_n_oe;
   endproperty
   a_reset_idle: assert property (p_reset_idle)
      else $error("link busy after reset");
   property p_req_common;
      $fell(bus_request_out_n) |-> cbrq_n_oe;
   endproperty
   a_req_common: assert property (p_req_common)
      else $error("request without common request");
   property p_req_bclk;
      $changed(bus_request_out_n) && !$past(srst) |-> $past(bclk, 2);
   endproperty
   a_req_bclk: assert property (p_req_bclk)
      else $error("request moved off bus clock");
   property p_claim_free;
      $rose(busy_n_oe) |-> !$past(far_busy_n_oe);
   endproperty
   a_claim_free: assert property (p_claim_free)
      else $error("claimed a busy bus");
   property p_claim_prio;
      $rose(busy_n_oe) |-> !$past(priority_in_n) || $past(forced_grant_in, 3);
   endproperty
   a_claim_prio: assert property (p_claim_prio)
      else $error("claimed without priority");
   property p_idle_common;
      bus_request_out_n |-> !cbrq_n_oe;
   endproperty
   a_idle_common: assert property (p_idle_common)
      else $error("common request while not asking");
   property p_release;
      $fell(busy_n_oe) && !$past(srst) |-> priority_in_n || bus_request_out_n;
   endproperty
   a_release: assert property (p_release)
      else $error("released while still granted");
   property p_keep;
      busy_n_oe && !priority_in_n && !bus_request_out_n |=> busy_n_oe;
   endproperty
   a_keep: assert property (p_keep)
      else $error("gave up bus unasked");
   // ========
   // covers
   c_claim: cover property ($rose(busy_n_oe));
   c_release: cover property ($fell(busy_n_oe));
   c_request: cover property ($fell(bus_request_out_n));
   c_forced: cover property ($rose(busy_n_oe) && bus_request_out_n);
endmodule // busmaster_assertions

// File: busmaster_backplane.sv
// far end: bus clock divider, priority resolver, other masters
// assumes one higher and one lower master, driven from user ports
`timescale 1ns/1ps
`include "busmaster_cfg.svh"
module busmaster_backplane #(
   parameter int BCLK_HALF = `BUS_CLK_HALF
)
(
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // backplane
   busmaster_if.backplane bus,
   // other masters
   input wire logic higher_request,
   input wire logic lower_wants_bus,
   input wire logic other_busy,
   // status
   output logic board_priority
);
   if (BCLK_HALF < 1 || BCLK_HALF > 255)
   begin : g_half_check
      $error("bus clock half period out of range");
   end

   typedef struct packed {
      logic [7:0] div;
      logic bclk;
      logic [1:0] req_s;
      logic prio;
      logic cbrq;
      logic busy;
   } state_t;

   state_t s_reg;
   state_t s_next;

   // ==================================================
   // resolver
   always_comb
   begin
      s_next = s_reg;
      s_next.req_s = {s_reg.req_s[0], !bus.bus_request_out_n};
      if (s_reg.div == 8'(BCLK_HALF - 1))
      begin
         s_next.div = 8'h00;
         s_next.bclk = !s_reg.bclk;
      end
      else
      begin
         s_next.div = s_reg.div + 8'h01;
      end
      // higher request withdraws the grant
      s_next.prio = s_reg.req_s[1] && !higher_request;
      s_next.cbrq = lower_wants_bus;
      s_next.busy = other_busy;
      if (srst)
      begin
         s_next = '0;
      end
   end

   always_ff @(posedge clk)
   begin
      s_reg <= s_next;
   end

   always_comb
   begin
      bus.bclk = s_reg.bclk;
      bus.priority_in_n = !s_reg.prio;
      bus.far_cbrq_n_oe = s_reg.cbrq;
      bus.far_busy_n_oe = s_reg.busy;
      board_priority = s_reg.prio;
   end
endmodule // busmaster_backplane

// File: busmaster_board.sv
// board end: mastership state machine plus address decoding
// assumes bus signals come from another clock domain (pins)
`timescale 1ns/1ps
`include "busmaster_cfg.svh"
module busmaster_board #(
   parameter int N_LIO = `N_LIO
)
(
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // backplane
   busmaster_if.board bus,
   // processor side
   input wire logic [19:0] cpu_addr,
   input wire logic cpu_io,
   input wire logic cpu_cycle,
   input wire logic cpu_lock,
   input wire logic nv_in_memory,
   // test inputs
   input wire logic forced_grant_in,
   input wire logic data_driver_kill,
   // status and enables
   output logic mastership_held,
   output logic bus_drive_enable,
   output logic command_enable,
   output logic local_space_select,
   output logic local_data_enable,
   output logic nvram_select,
   output logic [N_LIO-1:0] local_io_selects
);
   if (N_LIO != 8)
   begin : g_lio_check
      $error("only an eight-way io decode is served");
   end

   typedef struct packed {
      logic [1:0] bclk_s;
      logic [1:0] busy_s;
      logic [1:0] cbrq_s;
      logic [1:0] prio_s;
      logic [1:0] fg_s;
      logic [1:0] kill_s;
      logic bclk_d;
      busmaster_pkg::own_state_t st;
      logic req;
      logic busy_drv;
      logic aen;
      logic held;
      logic cmd_en;
      logic local_sel;
      logic data_en;
      logic nv_sel;
      logic [N_LIO-1:0] lio;
   } state_t;

   state_t s_reg;
   state_t s_next;
   logic bedge;
   logic sys_busy;
   logic lower_req;
   logic prio;
   logic is_local;
   logic nv_hit;
   logic lio_hit;
   logic rom_hit;

   // ==================================================
   // address decode
   always_comb
   begin
      nv_hit = nv_in_memory ?
         (!cpu_io && cpu_addr <= `NV_MEM_LAST) :
         (cpu_io && cpu_addr[15:0] >= `NV_IO_BASE);
      lio_hit = cpu_io && cpu_addr[15:0] >= `LIO_BASE &&
         cpu_addr[15:0] <= `LIO_LAST;
      rom_hit = !cpu_io && cpu_addr >= `ROM_BASE;
      // kill blanks local and bus access alike
      is_local = cpu_cycle && !s_reg.kill_s[1] &&
         (nv_hit || lio_hit || rom_hit);
   end

   // ==================================================
   // next state
   always_comb
   begin
      s_next = s_reg;
      s_next.bclk_s = {s_reg.bclk_s[0], bus.bclk};
      s_next.busy_s = {s_reg.busy_s[0], !bus.busy_n};
      s_next.cbrq_s = {s_reg.cbrq_s[0], !bus.common_request_n};
      s_next.prio_s = {s_reg.prio_s[0], !bus.priority_in_n};
      s_next.fg_s = {s_reg.fg_s[0], forced_grant_in};
      s_next.kill_s = {s_reg.kill_s[0], data_driver_kill};
      s_next.bclk_d = s_reg.bclk_s[1];
      bedge = s_reg.bclk_s[1] && !s_reg.bclk_d;
      prio = s_reg.prio_s[1];
      sys_busy = s_reg.busy_s[1] && !s_reg.busy_drv;
      lower_req = s_reg.cbrq_s[1] && !s_reg.req;
      // select and enables follow the processor directly
      s_next.local_sel = is_local;
      s_next.cmd_en = s_reg.aen && cpu_cycle && !is_local
         && !s_reg.kill_s[1];
      s_next.data_en = is_local;
      s_next.nv_sel = is_local && nv_hit;
      s_next.lio = '0;
      if (is_local && lio_hit)
      begin
         // a1 ignored, as the pair shares one select
         s_next.lio[{cpu_addr[3], cpu_addr[2], cpu_addr[0]}] = 1'b1;
      end
      if (bedge)
      begin
         case (s_reg.st)
            busmaster_pkg::ST_IDLE:
            begin
               if (s_reg.fg_s[1])
               begin
                  s_next.st = busmaster_pkg::ST_OWN;
                  s_next.busy_drv = 1'b1;
                  s_next.aen = 1'b1;
               end
               else if (cpu_cycle && !is_local && !s_reg.kill_s[1])
               begin
                  s_next.req = 1'b1;
                  s_next.st = busmaster_pkg::ST_WAIT;
               end
               else
               begin
                  s_next.req = 1'b0;
               end
            end
            busmaster_pkg::ST_WAIT:
            begin
               if (s_reg.fg_s[1] || (!sys_busy && prio))
               begin
                  s_next.st = busmaster_pkg::ST_OWN;
                  s_next.busy_drv = 1'b1;
                  s_next.aen = 1'b1;
               end
            end
            busmaster_pkg::ST_OWN:
            begin
               // a waiting lower master makes us drop our request
               if (lower_req || s_reg.cbrq_s[1])
               begin
                  s_next.req = 1'b0;
               end
               // release only between transfers, lock holds on
               if (!cpu_cycle && !cpu_lock && !s_reg.fg_s[1] &&
                  (!prio || !s_reg.req))
               begin
                  s_next.st = busmaster_pkg::ST_IDLE;
                  s_next.busy_drv = 1'b0;
                  s_next.aen = 1'b0;
                  s_next.req = 1'b0;
               end
            end
            default:
            begin
               s_next.st = busmaster_pkg::ST_IDLE;
            end
         endcase
      end
      // owner proceeds at once on any new system cycle while data_driver_kill is low
      s_next.held = (s_next.st == busmaster_pkg::ST_OWN);
      if (srst)
      begin
         s_next = '0;
         s_next.st = busmaster_pkg::ST_IDLE;
      end
   end

   always_ff @(posedge clk)
   begin
      s_reg <= s_next;
   end

   // ==================================================
   // outputs
   always_comb
   begin
      bus.busy_n_o = 1'b0;
      bus.busy_n_oe = s_reg.busy_drv;
      bus.cbrq_n_o = 1'b0;
      bus.cbrq_n_oe = s_reg.req && !s_reg.held;
      bus.bus_request_out_n = !s_reg.req;
      mastership_held = s_reg.held;
      bus_drive_enable = s_reg.aen;
      command_enable = s_reg.cmd_en;
      local_space_select = s_reg.local_sel;
      local_data_enable = s_reg.data_en;
      nvram_select = s_reg.nv_sel;
      local_io_selects = s_reg.lio;
   end
endmodule // busmaster_board

// File: busmaster_cfg.svh
// constants for the shared-bus mastership logic and its backplane partner
// assumes a 10 MHz clk; the bus clock arrives as a pin and is sampled
// Function
// - local select low means system cycle: request
// - busy asserted blocks every other requester
// - lower-priority master raises common request
// - forced grant takes the bus without arbitration
// - state advances only on bus clock edges
// - processor lock holds busy asserted
// - priority-in only when no higher request
// - mastership_held shows current bus control
// - drive enable gates command and address drivers
// - on-board cycles keep bus request low
// - already master: transfer proceeds at once
// - not master: toggle request, raise both requests
// - busy low with priority-in: claim bus
// - claiming busy presets drive enable together
// - hold busy until done, release without priority
// - higher request drops this board's priority-in
// - common request from below drops own request
// - no other requester: keep mastership idle
// - data-driver kill disables processor data drivers
// - local select suppresses bus command driver
// - nvram at io fe00-ffff or mem 00000-001ff
// - three-to-eight decode gives eight io selects
// - on-board address: one select plus local; rom space gives local alone
`ifndef BUSMASTER_CFG_SVH
`define BUSMASTER_CFG_SVH
`define NV_IO_BASE 16'hfe00
`define NV_IO_LAST 16'hffff
`define NV_MEM_BASE 20'h00000
`define NV_MEM_LAST 20'h001ff
`define LIO_BASE 16'h00e0
`define LIO_LAST 16'h00ef
`define ROM_BASE 20'hf8000
`define N_LIO 8
`define BUS_CLK_HALF 4
`endif

// File: busmaster_if.sv
// wires between the board and the backplane resolver
// open-drain lines resolve here: low when any side enables
`timescale 1ns/1ps
interface busmaster_if;
   logic bclk;
   logic busy_n_o;
   logic busy_n_oe;
   logic cbrq_n_o;
   logic cbrq_n_oe;
   logic far_busy_n_oe;
   logic far_cbrq_n_oe;
   logic bus_request_out_n;
   logic priority_in_n;
   wire busy_n = !((busy_n_oe && !busy_n_o) || far_busy_n_oe);
   wire common_request_n = !((cbrq_n_oe && !cbrq_n_o) || far_cbrq_n_oe);
   modport board
   (
      input bclk, busy_n, common_request_n, priority_in_n,
      output busy_n_o, busy_n_oe, cbrq_n_o, cbrq_n_oe, bus_request_out_n
   );
   modport backplane
   (
      input busy_n, common_request_n, bus_request_out_n,
      output bclk, far_busy_n_oe, far_cbrq_n_oe, priority_in_n
   );
endinterface

// File: busmaster_pkg.sv
// types used by the board end of the mastership link
// assumes nothing beyond the cfg header
package busmaster_pkg;
   typedef enum logic [2:0]
   {
      ST_IDLE = 3'b001,
      ST_WAIT = 3'b010,
      ST_OWN = 3'b100
   } own_state_t;
endpackage

// File: tb_system_bus_mastership_logic.sv
// bench: board and backplane joined, decode table then handoffs
// assumes the backplane divides clk into the bus clock
`timescale 1ns/1ps
module tb_system_bus_mastership_logic;
   typedef struct packed {logic io; logic [19:0] a; logic nv;
      logic [10:0] exp;} row_t;
   logic clk, srst, cpu_io, cpu_cycle, cpu_lock, nv_in_memory;
   logic data_driver_kill, higher_request, lower_wants_bus, other_busy;
   logic forced_grant_in;
   logic [19:0] cpu_addr;
   logic mastership_held, bus_drive_enable, command_enable;
   logic local_space_select, local_data_enable, nvram_select;
   logic [7:0] local_io_selects;
   int failures = 0;
   int checked = 0;
   busmaster_if bus_if();
   wire logic [4:0] st = {command_enable, mastership_held, bus_drive_enable,
      bus_if.bus_request_out_n, bus_if.busy_n};
   wire logic [10:0] dec = {bus_if.bus_request_out_n, local_space_select,
      nvram_select, local_io_selects};
   // expected: {request_n, local, nvram, io selects}
   row_t rows [8] = '{{1'b1, 20'h0fe00, 1'b0, 11'h700},
      {1'b1, 20'h0ffff, 1'b0, 11'h700}, {1'b0, 20'h001ff, 1'b1, 11'h700},
      {1'b1, 20'h000e0, 1'b0, 11'h601}, {1'b1, 20'h000e3, 1'b0, 11'h602},
      {1'b1, 20'h000ed, 1'b0, 11'h680}, {1'b1, 20'h000ea, 1'b0, 11'h610},
      {1'b0, 20'hf8000, 1'b0, 11'h600}};
   // forced grant is exercised last, once arbitration is proven
   busmaster_board busmaster_board_i (.clk, .srst, .bus(bus_if.board),
      .cpu_addr, .cpu_io, .cpu_cycle, .cpu_lock,
      .nv_in_memory, .forced_grant_in, .data_driver_kill,
      .mastership_held, .bus_drive_enable, .command_enable,
      .local_space_select, .local_data_enable, .nvram_select,
      .local_io_selects);
   busmaster_backplane #(.BCLK_HALF(4)) busmaster_backplane_i (.clk, .srst,
      .bus(bus_if.backplane), .higher_request, .lower_wants_bus,
      .other_busy, .board_priority());
   busmaster_assertions busmaster_assertions_i (.clk, .srst,
      .bclk(bus_if.bclk), .busy_n_oe(bus_if.busy_n_oe),
      .cbrq_n_oe(bus_if.cbrq_n_oe), .far_busy_n_oe(bus_if.far_busy_n_oe),
      .bus_request_out_n(bus_if.bus_request_out_n),
      .priority_in_n(bus_if.priority_in_n), .forced_grant_in);
   // ========
   // tasks
   task automatic chk(input logic [10:0] seen, input logic [10:0] exp);
      checked++;
      if (seen !== exp)
      begin
         failures++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic final_report();
      $display("checked=%0d failures=%0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic wait_held(input logic want);
      int n;
      n = 0;
      @(negedge clk);
      while (mastership_held !== want)
      begin
         n++;
         if (n > 400)
         begin
            failures++;
            final_report();
         end
         @(negedge clk);
      end
   endtask
   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // ========
   // sequence
   initial
   begin
      {srst, cpu_io, cpu_cycle, cpu_lock, nv_in_memory} = 5'h10;
      {data_driver_kill, higher_request, lower_wants_bus, other_busy} = 4'h0;
      forced_grant_in = 1'b0;
      cpu_addr = 20'h00000;
      repeat (12) @(posedge clk);
      srst <= 1'b0;
      repeat (2) @(posedge clk);
      foreach (rows[i])
      begin
         cpu_io <= rows[i].io;
         cpu_addr <= rows[i].a;
         nv_in_memory <= rows[i].nv;
         cpu_cycle <= 1'b1;
         repeat (3) @(posedge clk);
         @(negedge clk);
         chk(dec, rows[i].exp);
         @(posedge clk);
      end
      $display("decode rows done");
      cpu_io <= 1'b0;
      cpu_addr <= 20'h01000;
      nv_in_memory <= 1'b0;
      wait_held(1'b1);
      @(negedge clk);
      chk(11'(st), 11'h01c);
      @(posedge clk);
      cpu_cycle <= 1'b0;
      repeat (40) @(posedge clk);
      @(negedge clk);
      chk(11'(mastership_held), 11'h001);
      @(posedge clk);
      cpu_cycle <= 1'b1;
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk(11'({command_enable, mastership_held}), 11'h003);
      @(posedge clk);
      cpu_cycle <= 1'b0;
      cpu_lock <= 1'b1;
      higher_request <= 1'b1;
      repeat (40) @(posedge clk);
      cpu_lock <= 1'b0;
      @(negedge clk);
      chk(11'(mastership_held), 11'h001);
      wait_held(1'b0);
      chk(11'({st[3:2], st[0]}), 11'h001);
      $display("lock and higher master done");
      @(posedge clk);
      higher_request <= 1'b0;
      cpu_cycle <= 1'b1;
      wait_held(1'b1);
      @(posedge clk);
      cpu_cycle <= 1'b0;
      lower_wants_bus <= 1'b1;
      wait_held(1'b0);
      chk(11'(st[1:0]), 11'h003);
      $display("lower master done");
      @(posedge clk);
      lower_wants_bus <= 1'b0;
      other_busy <= 1'b1;
      cpu_cycle <= 1'b1;
      repeat (60) @(posedge clk);
      @(negedge clk);
      chk(11'(mastership_held), 11'h000);
      @(posedge clk);
      other_busy <= 1'b0;
      wait_held(1'b1);
      chk(11'(st[3:2]), 11'h003);
      $display("busy bus done");
      @(posedge clk);
      srst <= 1'b1;
      cpu_cycle <= 1'b0;
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk(11'(st[3:0]), 11'h003);
      @(posedge clk);
      srst <= 1'b0;
      repeat (2) @(posedge clk);
      data_driver_kill <= 1'b1;
      cpu_io <= 1'b1;
      cpu_addr <= 20'h0fe00;
      cpu_cycle <= 1'b1;
      repeat (4) @(posedge clk);
      @(negedge clk);
      chk(11'({local_space_select, local_data_enable}), 11'h000);
      $display("reset and kill done");
      @(posedge clk);
      data_driver_kill <= 1'b0;
      cpu_cycle <= 1'b0;
      forced_grant_in <= 1'b1;
      wait_held(1'b1);
      chk(11'({st[3:2], st[1]}), 11'h007);
      @(posedge clk);
      forced_grant_in <= 1'b0;
      wait_held(1'b0);
      chk(11'(st[0]), 11'h001);
      $display("forced grant done");
      final_report();
   end
endmodule // tb_system_bus_mastership_logic
